// >>> bench/mac_rx_pad_strip_loopback_tb_top.sv
`timescale 1ns/1ns
module mac_rx_pad_strip_loopback_tb_top;
	logic clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1;
	logic [5:0] avs_address_i = 6'h00;
	logic avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic avs_waitrequest_o, net_rx_valid_i, net_rx_sof_i, net_rx_eof_i;
	logic net_col_i, mac_tx_valid_i, mac_tx_sof_i, mac_tx_eof_i, irq_o;
	logic [7:0] net_rx_data_i, mac_tx_data_i, net_tx_data_o, fifo_data_o;
	logic net_tx_valid_o, net_tx_sof_o, net_tx_eof_o, codec_in_loop_o;
	logic tx_fcs_append_o, fifo_wr_o, fifo_commit_o, fifo_discard_o, last_com;
	logic [15:0] desc_status_o, last_desc, len;
	logic [7:0] fr [0:127];
	int n_fail = 0, comparisons = 0, n_wr = 0, last_wr = 0, n_end = 0;
	int tx_seen = 0, n = 64;
	mrxps_rx_frontend mrxps_rx_frontend_inst (.*);
	mrxps_net_model net_side (.clk_i(clk_i), .valid_o(net_rx_valid_i),
		.data_o(net_rx_data_i), .sof_o(net_rx_sof_i), .eof_o(net_rx_eof_i),
		.col_o(net_col_i));
	mrxps_net_model tx_side (.clk_i(clk_i), .valid_o(mac_tx_valid_i),
		.data_o(mac_tx_data_i), .sof_o(mac_tx_sof_i), .eof_o(mac_tx_eof_i),
		.col_o());
	initial
		forever
			#2 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		n_wr = n_wr + (fifo_wr_o === 1'b1);
		tx_seen = tx_seen + (net_tx_valid_o === 1'b1);
		if (fifo_commit_o === 1'b1 || fifo_discard_o === 1'b1)
		begin
			last_wr = n_wr;
			n_wr = 0;
			last_com = fifo_commit_o;
			last_desc = desc_status_o;
			n_end = n_end + 1;
		end
	end
	task complete_run;
		if (n_fail == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		for (k = 0; k < 20; k++)
		begin
			@(posedge clk_i);
			if (avs_waitrequest_o === 1'b0)
				break;
		end
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (k == 20)
		begin
			n_fail++;
			complete_run();
		end
	endtask : bus
	function automatic logic [31:0] crc(input int m);
		logic [31:0] c;
		c = mrxps_pkg::CRC_INIT;
		for (int i = 0; i < m; i++)
		begin
			c = c ^ {24'h0, fr[i]};
			for (int j = 0; j < 8; j++)
				c = c[0] ? (c >> 1) ^ mrxps_pkg::CRC_POLY : c >> 1;
		end
		return ~c;
	endfunction : crc
	// Frame with software FCS in its last four bytes
	task automatic build(input int nn, input logic [15:0] l, input logic bad);
		logic [31:0] c;
		n = nn;
		for (int i = 0; i < n; i++)
			fr[i] = 8'($urandom);
		fr[0] = fr[0] & 8'hfe;
		fr[12] = l[15:8];
		fr[13] = l[7:0];
		c = crc(n - 4) ^ {31'h0, bad};
		for (int i = 0; i < 4; i++)
			fr[n - 4 + i] = c[8 * i +: 8];
	endtask : build
	// ex: 0 nothing, 1 commit, 2 discard
	task automatic frame(input logic lp, input int col, input int ex,
		input int wr, input logic [3:0] fl);
		int e0;
		e0 = n_end;
		if (lp)
			tx_side.send(fr, n, -1);
		else
			net_side.send(fr, n, col);
		for (int k = 0; k < 9 && n_end == e0; k++)
			@(posedge clk_i);
		check("frame ends", 32'(n_end - e0), 32'(ex != 0));
		if (ex == 1)
			check("desc", {16'(last_wr), last_desc},
				{16'(wr), 12'(wr), fl});
		if (ex == 2)
			check("discarded", last_com, 1'b0);
	endtask : frame
	initial
	begin
		void'($urandom(37));
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		check("fcs append", tx_fcs_append_o, 1'b1);
		bus(1'b0, mrxps_pkg::OFF_MODE, 32'h0);
		check("mode reset", q, 32'h0);
		bus(1'b0, 6'h3c, 32'h0);
		check("unmapped", q, 32'h0);
		bus(1'b1, mrxps_pkg::OFF_FEATURE, 32'h0000_0400);
		for (int i = 0; i < 7; i++)
		begin
			len = i == 0 ? 16'h0000 : i == 1 ? 16'h002d : i == 2 ? 16'h002e
				: i == 3 ? 16'h0800 : 16'($urandom_range(45));
			build(i < 3 ? 64 : 64 + $urandom_range(40), len, i == 6);
			frame(1'b0, -1, 1, len < 46 ? 14 + len : n,
				{len < 46, 2'b00, i == 6});
		end
		bus(1'b1, mrxps_pkg::OFF_FEATURE, 32'h0);
		build(64, 16'h000a, 1'b0);
		frame(1'b0, -1, 1, 64, 4'h0);
		build(63, 16'h000a, 1'b0);
		frame(1'b0, -1, 2, 0, 4'h0);
		bus(1'b1, mrxps_pkg::OFF_TEST, 32'h8);
		frame(1'b0, -1, 1, 63, 4'h0);
		bus(1'b1, mrxps_pkg::OFF_TEST, 32'h0);
		build(80, 16'h0800, 1'b0);
		frame(1'b0, 20, 2, 0, 4'h0);
		frame(1'b0, 62, 2, 0, 4'h0);
		frame(1'b0, 66, 1, 80, 4'h2);
		bus(1'b0, mrxps_pkg::OFF_IRQ_STAT, 32'h0);
		check("irq status", q, 32'h7);
		check("irq masked", irq_o, 1'b0);
		bus(1'b1, mrxps_pkg::OFF_IRQ_MASK, 32'h7);
		repeat (2) @(posedge clk_i);
		check("irq unmasked", irq_o, 1'b1);
		bus(1'b1, mrxps_pkg::OFF_IRQ_STAT, 32'h7);
		bus(1'b1, mrxps_pkg::OFF_IRQ_MASK, 32'h0);
		bus(1'b0, mrxps_pkg::OFF_IRQ_STAT, 32'h0);
		check("irq cleared", q, 32'h0);
		check("irq low", irq_o, 1'b0);
		bus(1'b1, mrxps_pkg::OFF_MODE, 32'h4c);
		repeat (2) @(posedge clk_i);
		check("fcs append", tx_fcs_append_o, 1'b0);
		check("codec outside loop", codec_in_loop_o, 1'b0);
		build(64, 16'h0800, 1'b1);
		frame(1'b1, -1, 1, 64, 4'h1);
		frame(1'b0, -1, 0, 0, 4'h0);
		bus(1'b1, mrxps_pkg::OFF_MODE, 32'h44);
		frame(1'b1, -1, 1, 64, 4'h0);
		bus(1'b1, mrxps_pkg::OFF_FEATURE, 32'h400);
		build(64, 16'h000a, 1'b0);
		frame(1'b1, -1, 1, 24, 4'h8);
		check("tx quiet", tx_seen, 32'h0);
		bus(1'b1, mrxps_pkg::OFF_MODE, 32'h4);
		repeat (2) @(posedge clk_i);
		check("codec in loop", codec_in_loop_o, 1'b1);
		tx_side.send(fr, n, -1);
		repeat (2) @(posedge clk_i);
		check("tx to network", tx_seen, 32'h40);
		bus(1'b1, mrxps_pkg::OFF_MODE, 32'h204);
		frame(1'b1, -1, 1, 24, 4'h8);
		complete_run();
	end
endmodule : mac_rx_pad_strip_loopback_tb_top

// >>> bench/mrxps_net_model.sv
`timescale 1ns/1ns
module mrxps_net_model (
	input wire logic clk_i,
	output logic valid_o,
	output logic [7:0] data_o,
	output logic sof_o,
	output logic eof_o,
	output logic col_o
);
	initial
	begin
		valid_o = 1'b0;
		data_o = 8'h00;
		sof_o = 1'b0;
		eof_o = 1'b0;
		col_o = 1'b0;
	end
	// Collision level from byte col until frame end
	task automatic send(input logic [7:0] b [0:127], input int n,
		input int col);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_i);
			valid_o <= 1'b1;
			data_o <= b[i];
			sof_o <= i == 0;
			if (i == col)
				col_o <= 1'b1;
		end
		@(posedge clk_i);
		valid_o <= 1'b0;
		sof_o <= 1'b0;
		data_o <= ~b[n - 1];
		eof_o <= 1'b1;
		@(posedge clk_i);
		eof_o <= 1'b0;
		col_o <= 1'b0;
	endtask : send
endmodule : mrxps_net_model

// >>> bench/mrxps_rx_checker.sv
`timescale 1ns/1ns
module mrxps_rx_checker #(
	parameter int CNT_W = 11
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic mac_tx_valid_i,
	input wire logic [7:0] mac_tx_data_i,
	input wire logic mac_tx_eof_i,
	input wire logic net_rx_valid_i,
	input wire logic net_rx_eof_i,
	input wire logic net_col_i,
	input wire logic net_tx_valid_o,
	input wire logic [7:0] net_tx_data_o,
	input wire logic tx_fcs_append_o,
	input wire logic fifo_wr_o,
	input wire logic fifo_commit_o,
	input wire logic fifo_discard_o,
	input wire logic [15:0] desc_status_o,
	input wire logic irq_o
);
	logic [11:0] n_wr;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// Bytes written since last commit or discard
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			n_wr <= 12'h000;
		else if (fifo_commit_o || fifo_discard_o)
			n_wr <= 12'h000;
		else if (fifo_wr_o)
			n_wr <= n_wr + 12'h001;
	end
	sequence s_taken;
		ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	property p_answer;
		s_taken |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
	endproperty
	a_answer: assert property (p_answer)
		else $error("bus answer not one cycle");
	property p_fcs_dflt;
		$rose(nrst_i) |-> tx_fcs_append_o && avs_waitrequest_o;
	endproperty
	a_fcs_dflt: assert property (p_fcs_dflt)
		else $error("fcs append low after reset");
	property p_tx_copy;
		$past(ce_i) && net_tx_valid_o |-> $past(mac_tx_valid_i)
			&& net_tx_data_o == $past(mac_tx_data_i);
	endproperty
	a_tx_copy: assert property (p_tx_copy)
		else $error("network byte not a copy of transmit byte");
	property p_desc_cnt;
		fifo_commit_o |-> desc_status_o[15:4] == n_wr;
	endproperty
	a_desc_cnt: assert property (p_desc_cnt)
		else $error("descriptor count differs from bytes written");
	property p_commit_src;
		fifo_commit_o |-> $past(net_rx_eof_i || mac_tx_eof_i);
	endproperty
	a_commit_src: assert property (p_commit_src)
		else $error("commit without end of frame");
	property p_wr_src;
		fifo_wr_o |-> $past(net_rx_valid_i || mac_tx_valid_i);
	endproperty
	a_wr_src: assert property (p_wr_src)
		else $error("fifo write without received byte");
	property p_discard_src;
		fifo_discard_o |-> $past(net_col_i || net_rx_eof_i || mac_tx_eof_i);
	endproperty
	a_discard_src: assert property (p_discard_src)
		else $error("discard without collision or end of frame");
	property p_irq_src;
		$rose(irq_o) |-> $past(fifo_commit_o || fifo_discard_o)
			|| $past(avs_write_i) || $past(avs_write_i, 2);
	endproperty
	a_irq_src: assert property (p_irq_src)
		else $error("interrupt rose without event");
endmodule : mrxps_rx_checker

bind mrxps_rx_frontend mrxps_rx_checker #(.CNT_W(CNT_W))
	mrxps_rx_checker_inst (.*);

// >>> verilog/mrxps_pkg.sv
package mrxps_pkg;
	// Register byte offsets
	localparam logic [5:0] OFF_FEATURE = 6'h00;
	localparam logic [5:0] OFF_MODE = 6'h04;
	localparam logic [5:0] OFF_TEST = 6'h08;
	localparam logic [5:0] OFF_HASH_LO = 6'h0c;
	localparam logic [5:0] OFF_HASH_HI = 6'h10;
	localparam logic [5:0] OFF_IRQ_STAT = 6'h14;
	localparam logic [5:0] OFF_IRQ_MASK = 6'h18;
	localparam logic [5:0] OFF_RX_DESC = 6'h1c;
	// Field positions and widths
	localparam int BIT_PAD_STRIP = 10;
	localparam int BIT_LOOP_EN = 2;
	localparam int BIT_TX_FCS_DIS = 3;
	localparam int BIT_INT_LOOP = 6;
	localparam int BIT_CODEC_LOOP = 8;
	localparam int BIT_TP_PORT = 9;
	localparam int BIT_RUNT_ACCEPT = 3;
	localparam int IRQ_W = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FCS = 1;
	localparam int IRQ_DELETED = 2;
	localparam int DESC_FCS_ERR = 0;
	localparam int DESC_LATE_COL = 1;
	localparam int DESC_HASH_HIT = 2;
	localparam int DESC_STRIPPED = 3;
	localparam int DESC_CNT_LSB = 4;
	localparam int DESC_CNT_W = 12;
	// Reset values
	localparam logic [31:0] RST_FEATURE = 32'h0000_0000;
	localparam logic [31:0] RST_MODE = 32'h0000_0000;
	localparam logic [31:0] RST_TEST = 32'h0000_0000;
	localparam logic [63:0] RST_HASH = 64'h0;
	// Frame layout and limits, in bytes
	localparam int LEN_HI_IDX = 12;
	localparam int LEN_LO_IDX = 13;
	localparam int HDR_BYTES = 14;
	localparam int DA_LAST_IDX = 5;
	localparam int STRIP_LIMIT = 46;
	localparam int MIN_FRAME = 64;
	localparam int SLOT_BYTES = 512 / 8;
	// Reflected CRC-32
	localparam logic [31:0] CRC_POLY = 32'hedb8_8320;
	localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
	localparam logic [31:0] CRC_RESIDUE = 32'hdebb_20e3;
	typedef enum {RX_IDLE, RX_RECV, RX_DROP} mrxps_state_t;
endpackage : mrxps_pkg

// >>> verilog/mrxps_rx_frontend.sv
// How it works
// [RL1] Feature bit 10 set enables automatic receive pad stripping.
// [RL2] Stripped pad and trailing FCS never reach the receive FIFO.
// [RL3] Length below 46: keep header plus that many data bytes only.
// [RL4] Length/type 46 or more passes unmodified, stripping or not.
// [RL5] FCS checked over all bytes incl. pad; mismatch flags descriptor.
// [RL6] Collision inside first 512 bit times deletes frame from FIFO.
// [RL7] Frames under 64 bytes discarded unless runt accept is set.
// [RL8] Deletion rewinds only the current frame; earlier frames stay.
// [RL9] Loopback with FCS enabled: transmitter appends, no receive check.
// [RL10] FCS disabled: software supplies FCS, receiver computes and checks.
// [RL11] Loop, codec loop and internal loop bits pick the loop path.
// [RL12] Multicast hash result valid in loopback only with FCS disabled.
// [RL13] Loopback otherwise behaves as normal, stripping included.
// [RL14] Internal loopback: nothing transmitted, network receive ignored.
// [RL15] AUI external loopback: transmit to network, keep receiving.
// [RL16] Twisted-pair external loopback: tx fed to rx, no collision.
// [RL17] Software keeps loopback frames 64 bytes unless runts accepted.
// [RL18] Transmit FCS disable reads zero after reset.
// [RL19] Length field taken most significant byte first.
`timescale 1ns/1ns
module mrxps_rx_frontend #(
	parameter int CNT_W = 11
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic net_rx_valid_i,
	input wire logic [7:0] net_rx_data_i,
	input wire logic net_rx_sof_i,
	input wire logic net_rx_eof_i,
	input wire logic net_col_i,
	input wire logic mac_tx_valid_i,
	input wire logic [7:0] mac_tx_data_i,
	input wire logic mac_tx_sof_i,
	input wire logic mac_tx_eof_i,
	output logic net_tx_valid_o,
	output logic [7:0] net_tx_data_o,
	output logic net_tx_sof_o,
	output logic net_tx_eof_o,
	output logic codec_in_loop_o,
	output logic tx_fcs_append_o,
	output logic fifo_wr_o,
	output logic [7:0] fifo_data_o,
	output logic fifo_commit_o,
	output logic fifo_discard_o,
	output logic [15:0] desc_status_o,
	output logic irq_o
);
	localparam logic [CNT_W-1:0] MAX_CNT = '1;

	if (CNT_W < 7 || CNT_W > mrxps_pkg::DESC_CNT_W)
	begin : g_bad_cnt_w
		$error("CNT_W must lie between 7 and 12");
	end

	logic [1:0] rst_sync;
	logic rst_n;
	logic [31:0] feature_control_reg;
	logic [31:0] mode_reg;
	logic [31:0] test_feature_reg;
	logic [63:0] multicast_hash_filter;
	logic [mrxps_pkg::IRQ_W-1:0] irq_stat;
	logic [mrxps_pkg::IRQ_W-1:0] irq_mask;
	logic [mrxps_pkg::IRQ_W-1:0] irq_event;
	logic [15:0] rx_descriptor_word1;
	logic bus_req;
	logic bus_fire;
	logic [31:0] next_rdata;
	logic [31:0] wmask;
	logic rx_pad_strip_en;
	logic runt_accept_en;
	logic tx_fcs_disable;
	logic loop_en;
	logic internal_loop_sel;
	logic codec_loop_sel;
	logic tp_port_sel;
	logic loop_internal;
	logic loop_tp_ext;
	logic use_tx;
	logic s_valid;
	logic [7:0] s_data;
	logic s_sof;
	logic s_eof;
	logic s_col;
	mrxps_pkg::mrxps_state_t state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] wr_cnt;
	logic [15:0] len_field;
	logic [31:0] crc;
	logic [31:0] next_crc;
	logic strip_f;
	logic check_f;
	logic mcast_f;
	logic hash_hit;
	logic late_col;
	logic stripped;
	logic keep_byte;
	logic [5:0] hash_idx;
	logic runt;
	logic fcs_bad;

	function automatic logic [31:0] crc_byte(input logic [31:0] c,
		input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
		begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ mrxps_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_byte

	// Reset release through two flops
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	assign rx_pad_strip_en = feature_control_reg[mrxps_pkg::BIT_PAD_STRIP];
	assign runt_accept_en = test_feature_reg[mrxps_pkg::BIT_RUNT_ACCEPT];
	assign tx_fcs_disable = mode_reg[mrxps_pkg::BIT_TX_FCS_DIS];
	assign loop_en = mode_reg[mrxps_pkg::BIT_LOOP_EN];
	assign internal_loop_sel = mode_reg[mrxps_pkg::BIT_INT_LOOP];
	assign codec_loop_sel = mode_reg[mrxps_pkg::BIT_CODEC_LOOP];
	assign tp_port_sel = mode_reg[mrxps_pkg::BIT_TP_PORT];

	// Bus: taken at first edge, answered one cycle later
	assign bus_req = avs_read_i | avs_write_i;
	assign bus_fire = bus_req & ~avs_waitrequest_o;
	for (genvar b = 0; b < 4; b++)
	begin : g_wmask
		assign wmask[8*b+:8] = {8{avs_byteenable_i[b]}};
	end

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		unique case (avs_address_i)
			mrxps_pkg::OFF_FEATURE: next_rdata = feature_control_reg;
			mrxps_pkg::OFF_MODE: next_rdata = mode_reg;
			mrxps_pkg::OFF_TEST: next_rdata = test_feature_reg;
			mrxps_pkg::OFF_HASH_LO: next_rdata = multicast_hash_filter[31:0];
			mrxps_pkg::OFF_HASH_HI: next_rdata = multicast_hash_filter[63:32];
			mrxps_pkg::OFF_IRQ_STAT: next_rdata[mrxps_pkg::IRQ_W-1:0] = irq_stat;
			mrxps_pkg::OFF_IRQ_MASK: next_rdata[mrxps_pkg::IRQ_W-1:0] = irq_mask;
			mrxps_pkg::OFF_RX_DESC: next_rdata[15:0] = rx_descriptor_word1;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
		end
		else if (ce_i)
		begin
			if (bus_req && avs_waitrequest_o)
			begin
				avs_waitrequest_o <= 1'b0;
				avs_readdata_o <= next_rdata;
			end
			else
				avs_waitrequest_o <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			feature_control_reg <= mrxps_pkg::RST_FEATURE;
			mode_reg <= mrxps_pkg::RST_MODE; // RL18
			test_feature_reg <= mrxps_pkg::RST_TEST;
			multicast_hash_filter <= mrxps_pkg::RST_HASH;
			irq_mask <= '0;
		end
		else if (ce_i && bus_fire && avs_write_i)
		begin
			unique case (avs_address_i)
				mrxps_pkg::OFF_FEATURE: feature_control_reg <=
					(feature_control_reg & ~wmask) | (avs_writedata_i & wmask);
				mrxps_pkg::OFF_MODE: mode_reg <=
					(mode_reg & ~wmask) | (avs_writedata_i & wmask);
				mrxps_pkg::OFF_TEST: test_feature_reg <=
					(test_feature_reg & ~wmask) | (avs_writedata_i & wmask);
				mrxps_pkg::OFF_HASH_LO: multicast_hash_filter[31:0] <=
					(multicast_hash_filter[31:0] & ~wmask) |
					(avs_writedata_i & wmask);
				mrxps_pkg::OFF_HASH_HI: multicast_hash_filter[63:32] <=
					(multicast_hash_filter[63:32] & ~wmask) |
					(avs_writedata_i & wmask);
				mrxps_pkg::OFF_IRQ_MASK: if (avs_byteenable_i[0])
					irq_mask <= avs_writedata_i[mrxps_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Sticky status, write one to clear; a new event wins
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_stat <= '0;
			irq_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (bus_fire && avs_write_i && avs_byteenable_i[0] &&
				avs_address_i == mrxps_pkg::OFF_IRQ_STAT)
				irq_stat <= (irq_stat &
					~avs_writedata_i[mrxps_pkg::IRQ_W-1:0]) | irq_event;
			else
				irq_stat <= irq_stat | irq_event;
			irq_o <= |((irq_stat | irq_event) & irq_mask);
		end
	end

	// Loopback path selection
	assign loop_internal = loop_en & internal_loop_sel; // RL11
	assign loop_tp_ext = loop_en & ~internal_loop_sel & tp_port_sel; // RL11
	assign use_tx = loop_internal | loop_tp_ext; // RL14 RL16
	assign s_valid = use_tx ? mac_tx_valid_i : net_rx_valid_i;
	assign s_data = use_tx ? mac_tx_data_i : net_rx_data_i;
	assign s_sof = use_tx ? mac_tx_sof_i : net_rx_sof_i;
	assign s_eof = use_tx ? mac_tx_eof_i : net_rx_eof_i;
	assign s_col = ~use_tx & net_col_i; // RL15 RL16

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			net_tx_valid_o <= 1'b0;
			net_tx_data_o <= 8'h00;
			net_tx_sof_o <= 1'b0;
			net_tx_eof_o <= 1'b0;
			codec_in_loop_o <= 1'b0;
			tx_fcs_append_o <= 1'b1;
		end
		else if (ce_i)
		begin
			net_tx_valid_o <= mac_tx_valid_i & ~loop_internal; // RL14 RL15
			net_tx_data_o <= loop_internal ? 8'h00 : mac_tx_data_i;
			net_tx_sof_o <= mac_tx_sof_i & ~loop_internal;
			net_tx_eof_o <= mac_tx_eof_i & ~loop_internal;
			codec_in_loop_o <= loop_en & (~internal_loop_sel | codec_loop_sel);
			tx_fcs_append_o <= ~tx_fcs_disable; // RL9 RL10
		end
	end

	// Receive byte path
	assign next_crc = crc_byte(crc, s_data);
	assign hash_idx = {next_crc[0], next_crc[1], next_crc[2],
		next_crc[3], next_crc[4], next_crc[5]};
	always_comb
	begin
		keep_byte = 1'b1;
		if (strip_f && cnt >= CNT_W'(mrxps_pkg::HDR_BYTES) &&
			len_field < 16'(mrxps_pkg::STRIP_LIMIT)) // RL3 RL4
			keep_byte = 32'(cnt) < mrxps_pkg::HDR_BYTES + 32'(len_field); // RL2
	end
	assign runt = cnt < CNT_W'(mrxps_pkg::MIN_FRAME) & ~runt_accept_en; // RL7
	assign fcs_bad = check_f & (crc != mrxps_pkg::CRC_RESIDUE); // RL5

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= mrxps_pkg::RX_IDLE;
			cnt <= '0;
			wr_cnt <= '0;
			len_field <= 16'h0000;
			crc <= mrxps_pkg::CRC_INIT;
			strip_f <= 1'b0;
			check_f <= 1'b0;
			mcast_f <= 1'b0;
			hash_hit <= 1'b0;
			late_col <= 1'b0;
			stripped <= 1'b0;
			fifo_wr_o <= 1'b0;
			fifo_data_o <= 8'h00;
			fifo_commit_o <= 1'b0;
			fifo_discard_o <= 1'b0;
			desc_status_o <= 16'h0000;
			rx_descriptor_word1 <= 16'h0000;
			irq_event <= '0;
		end
		else if (ce_i)
		begin
			fifo_wr_o <= 1'b0;
			fifo_commit_o <= 1'b0;
			fifo_discard_o <= 1'b0;
			irq_event <= '0;
			unique case (state)
				mrxps_pkg::RX_IDLE:
					if (s_valid && s_sof)
					begin
						state <= mrxps_pkg::RX_RECV;
						cnt <= CNT_W'(1);
						wr_cnt <= CNT_W'(1);
						crc <= crc_byte(mrxps_pkg::CRC_INIT, s_data);
						strip_f <= rx_pad_strip_en; // RL1 RL13
						check_f <= ~loop_en | tx_fcs_disable; // RL9 RL10 RL12
						mcast_f <= s_data[0];
						hash_hit <= 1'b0;
						late_col <= 1'b0;
						stripped <= 1'b0;
						len_field <= 16'h0000;
						fifo_wr_o <= 1'b1;
						fifo_data_o <= s_data;
					end
				mrxps_pkg::RX_RECV:
					if (s_col && cnt < CNT_W'(mrxps_pkg::SLOT_BYTES))
					begin
						fifo_discard_o <= 1'b1; // RL6 RL8
						irq_event[mrxps_pkg::IRQ_DELETED] <= 1'b1;
						state <= s_eof ? mrxps_pkg::RX_IDLE : mrxps_pkg::RX_DROP;
					end
					else if (s_eof)
					begin
						state <= mrxps_pkg::RX_IDLE;
						if (runt)
						begin
							fifo_discard_o <= 1'b1; // RL7 RL8
							irq_event[mrxps_pkg::IRQ_DELETED] <= 1'b1;
						end
						else
						begin
							fifo_commit_o <= 1'b1;
							desc_status_o <=
								{(mrxps_pkg::DESC_CNT_W)'(wr_cnt), stripped,
								hash_hit & check_f, late_col | s_col, fcs_bad};
							rx_descriptor_word1 <=
								{(mrxps_pkg::DESC_CNT_W)'(wr_cnt), stripped,
								hash_hit & check_f, late_col | s_col, fcs_bad}; // RL5
							irq_event[mrxps_pkg::IRQ_DONE] <= 1'b1;
							irq_event[mrxps_pkg::IRQ_FCS] <= fcs_bad;
						end
					end
					else
					begin
						if (s_col)
							late_col <= 1'b1;
						if (s_valid)
						begin
							crc <= next_crc; // RL5
							if (cnt != MAX_CNT)
								cnt <= cnt + CNT_W'(1);
							if (cnt == CNT_W'(mrxps_pkg::LEN_HI_IDX))
								len_field[15:8] <= s_data; // RL19
							if (cnt == CNT_W'(mrxps_pkg::LEN_LO_IDX))
								len_field[7:0] <= s_data; // RL19
							if (cnt == CNT_W'(mrxps_pkg::DA_LAST_IDX))
								hash_hit <= mcast_f &
									multicast_hash_filter[hash_idx]; // RL12
							if (keep_byte)
							begin
								fifo_wr_o <= 1'b1;
								fifo_data_o <= s_data;
								if (wr_cnt != MAX_CNT)
									wr_cnt <= wr_cnt + CNT_W'(1);
							end
							else
								stripped <= 1'b1; // RL2
						end
					end
				mrxps_pkg::RX_DROP:
					if (s_eof)
						state <= mrxps_pkg::RX_IDLE;
			endcase
		end
	end
endmodule : mrxps_rx_frontend
